// ===== hw/led_pattern_pkg.sv
// Overview of operation
// - period codes 0..0x7E repeat blinking
// - code 0x7F runs the pattern once
// - rise and fall codes 0..0xF
// - scaling factor multiplies ramp durations
// - ramp shape linear or logarithmic
// - steady current except PWM during ramps
// - separate rise and fall durations
// - own current level per channel
// - timers take 0..255 on fraction
// - on time includes rise; fall follows
// - per channel source; 0x08 puts channel 1 on the first timer
// - second timer starts in one of four slots
// - pulses cut at period end
package led_pattern_pkg;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 4;
	localparam int PERIOD_UNIT_NS  = 4096;
	localparam int PERIOD_UNIT_CYC = (PERIOD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_UNIT_NS    = 2048;
	localparam int RAMP_UNIT_CYC   = (RAMP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PER_CNT_W       = 17;
	localparam int RAMP_CNT_W      = 16;
	localparam int NUM_CH          = 4;

	// -------------------------------------------------------------
	// codes and fields
	// -------------------------------------------------------------
	localparam logic [6:0] FP_ONE_SHOT   = 7'h7F;
	localparam logic [7:0] SLOT_STEP     = 8'h40;
	localparam logic [7:0] DUTY_FULL     = 8'hFF;
	localparam logic [7:0] DUTY_OFF      = 8'h00;
	localparam logic [7:0] PHASE_LAST    = 8'hFF;
	localparam int         PER_LOG_BIT   = 7;
	localparam int         PER_SCALE_LSB = 8;
	localparam int         T2_SLOT_LSB   = 8;
	localparam int         RAMP_FALL_LSB = 4;
	localparam int         ST_DONE_BIT   = 8;
	localparam int         ST_T1_BIT     = 9;
	localparam int         ST_T2_BIT     = 10;

	typedef enum logic [1:0] {
		SRC_OFF    = 2'h0,
		SRC_ON     = 2'h1,
		SRC_FIRST_BLINK_TIMER = 2'h2,
		SRC_SECOND_BLINK_TIMER = 2'h3
	} src_sel_e;

	// -------------------------------------------------------------
	// register map
	// -------------------------------------------------------------
	localparam logic [7:0] ADDR_PERIOD = 8'h00;
	localparam logic [7:0] ADDR_FIRST_BLINK_TIMER = 8'h04;
	localparam logic [7:0] ADDR_SECOND_BLINK_TIMER = 8'h08;
	localparam logic [7:0] ADDR_SOURCE = 8'h0C;
	localparam logic [7:0] ADDR_RAMP   = 8'h10;
	localparam logic [7:0] ADDR_CUR0   = 8'h14;
	localparam logic [7:0] ADDR_STEP   = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h24;

	function automatic logic in_window(input logic [7:0] phase,
		input logic [7:0] start, input logic [7:0] len);
		logic [7:0] ofs;
		ofs = phase - start;
		return (phase >= start) && (ofs < len);
	endfunction

	function automatic logic [RAMP_CNT_W-1:0] ramp_limit(input logic [3:0] code,
		input logic [1:0] scale);
		logic [RAMP_CNT_W-1:0] base;
		base = RAMP_CNT_W'(int'(code) * RAMP_UNIT_CYC);
		return base << scale;
	endfunction

	function automatic logic [PER_CNT_W-1:0] period_limit(input logic [6:0] code);
		return PER_CNT_W'((int'(code) + 1) * PERIOD_UNIT_CYC);
	endfunction

endpackage

// ===== hw/brightness_ramp.sv
module brightness_ramp
	import led_pattern_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       on_i,
	input  wire logic [3:0] rise_code_i,
	input  wire logic [3:0] fall_code_i,
	input  wire logic [1:0] scale_i,
	input  wire logic       log_shape_i,
	output logic      [7:0] duty_o
);

	typedef enum logic [1:0] {ST_LOW, ST_RISE, ST_HIGH, ST_FALL} ramp_state_e;

	ramp_state_e           state_ff,  nxt_state;
	logic [7:0]            level_ff,  nxt_level;
	logic [RAMP_CNT_W-1:0] cnt_ff,    nxt_cnt;
	logic [7:0]            duty_ff,   nxt_duty;
	logic [RAMP_CNT_W-1:0] limit;
	logic                  step_due;
	logic [15:0]           sq;

	always_comb begin
		nxt_state = state_ff;
		nxt_level = level_ff;
		nxt_cnt   = cnt_ff;
		limit     = ramp_limit(on_i ? rise_code_i : fall_code_i, scale_i);
		step_due  = (limit == '0) || (cnt_ff >= limit - 1'b1);
		case (state_ff)
			ST_LOW: begin
				if (on_i) begin
					nxt_state = ST_RISE;
					nxt_cnt   = '0;
				end
			end
			ST_RISE: begin
				if (!on_i) begin
					nxt_state = ST_FALL;
					nxt_cnt   = '0;
				end else if (step_due) begin
					nxt_cnt   = '0;
					nxt_level = (limit == '0) ? DUTY_FULL : level_ff + 1'b1;
					if (limit == '0 || level_ff == DUTY_FULL - 1'b1) begin
						nxt_state = ST_HIGH;
					end
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			ST_HIGH: begin
				if (!on_i) begin
					nxt_state = ST_FALL;
					nxt_cnt   = '0;
				end
			end
			ST_FALL: begin
				if (on_i) begin
					nxt_state = ST_RISE;
					nxt_cnt   = '0;
				end else if (step_due) begin
					nxt_cnt   = '0;
					nxt_level = (limit == '0) ? DUTY_OFF : level_ff - 1'b1;
					if (limit == '0 || level_ff == DUTY_OFF + 1'b1) begin
						nxt_state = ST_LOW;
					end
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			default: begin
				nxt_state = ST_LOW;
				nxt_level = DUTY_OFF;
			end
		endcase
		sq       = {8'h00, level_ff} * ({8'h00, level_ff} + 16'h0001);
		nxt_duty = log_shape_i ? sq[15:8] : level_ff;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_LOW;
			level_ff <= DUTY_OFF;
			cnt_ff   <= '0;
			duty_ff  <= DUTY_OFF;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			level_ff <= nxt_level;
			cnt_ff   <= nxt_cnt;
			duty_ff  <= nxt_duty;
		end
	end

	assign duty_o = duty_ff;

endmodule // brightness_ramp

// ===== hw/pwm_modulator.sv
module pwm_modulator
	import led_pattern_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] pwm_cnt_i,
	input  wire logic [7:0] duty_i,
	output logic            on_o
);

	logic on_ff, nxt_on;

	always_comb begin
		nxt_on = (duty_i == DUTY_FULL) || (duty_i > pwm_cnt_i);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			on_ff <= 1'b0;
		end else if (ce_i) begin
			on_ff <= nxt_on;
		end
	end

	assign on_o = on_ff;

endmodule // pwm_modulator

// ===== hw/led_pattern_top.sv
// Chosen here: the AHB-Lite slave port and the address map.
module led_pattern_top
	import led_pattern_pkg::*;
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    ce_i,
	input  wire logic                    hsel_i,
	input  wire logic [31:0]             haddr_i,
	input  wire logic [1:0]              htrans_i,
	input  wire logic                    hwrite_i,
	input  wire logic [2:0]              hsize_i,
	input  wire logic [31:0]             hwdata_i,
	input  wire logic                    hready_i,
	output logic      [31:0]             hrdata_o,
	output logic                         hreadyout_o,
	output logic                         hresp_o,
	output logic      [NUM_CH-1:0]       ch_on_o,
	output logic      [NUM_CH-1:0][7:0]  channel_current_level_o
);

	typedef enum logic {PER_RUN, PER_DONE} period_state_e;

	// -------------------------------------------------------------
	// bus slave state
	// -------------------------------------------------------------
	logic        wr_pend_ff,  nxt_wr_pend;
	logic [7:0]  wr_addr_ff,  nxt_wr_addr;
	logic [31:0] hrdata_ff,   nxt_hrdata;
	logic        addr_phase;
	logic [31:0] rd_word;

	// -------------------------------------------------------------
	// configuration registers
	// -------------------------------------------------------------
	logic [6:0]             period_ff,  nxt_period;
	logic                   log_ff,     nxt_log;
	logic [1:0]             scale_ff,   nxt_scale;
	logic [7:0]             ton1_ff,    nxt_ton1;
	logic [7:0]             ton2_ff,    nxt_ton2;
	logic [1:0]             slot_ff,    nxt_slot;
	logic [7:0]             src_ff,     nxt_src;
	logic [3:0]             rise_ff,    nxt_rise;
	logic [3:0]             fall_ff,    nxt_fall;
	logic [NUM_CH-1:0][7:0] cur_ff,     nxt_cur;
	logic                   restart;

	// -------------------------------------------------------------
	// pattern state
	// -------------------------------------------------------------
	period_state_e          pstate_ff,  nxt_pstate;
	logic [PER_CNT_W-1:0]   div_ff,     nxt_div;
	logic [7:0]             phase_ff,   nxt_phase;
	logic                   t1_on_ff,   nxt_t1_on;
	logic                   t2_on_ff,   nxt_t2_on;
	logic [7:0]             pwm_cnt_ff, nxt_pwm_cnt;
	logic [7:0]             t2_start;
	logic [7:0]             duty1;
	logic [7:0]             duty2;
	logic [NUM_CH-1:0][7:0] ch_duty;
	logic                   phase_end;

	// -------------------------------------------------------------
	// bus slave
	// -------------------------------------------------------------
	always_comb begin
		addr_phase = hsel_i && hready_i && htrans_i[1];
		rd_word    = '0;
		case (haddr_i[7:0])
			ADDR_PERIOD: rd_word = {22'h0, scale_ff, log_ff, period_ff};
			ADDR_FIRST_BLINK_TIMER: rd_word = {24'h0, ton1_ff};
			ADDR_SECOND_BLINK_TIMER: rd_word = {22'h0, slot_ff, ton2_ff};
			ADDR_SOURCE: rd_word = {24'h0, src_ff};
			ADDR_RAMP:   rd_word = {24'h0, fall_ff, rise_ff};
			ADDR_STATUS: rd_word = {21'h0, t2_on_ff, t1_on_ff,
				pstate_ff == PER_DONE, phase_ff};
			default: begin
				for (int n = 0; n < NUM_CH; n++) begin
					if (haddr_i[7:0] == ADDR_CUR0 + 8'(n) * ADDR_STEP) begin
						rd_word = {24'h0, cur_ff[n]};
					end
				end
			end
		endcase
		nxt_wr_pend = addr_phase && hwrite_i;
		nxt_wr_addr = addr_phase ? haddr_i[7:0] : wr_addr_ff;
		// read data held for the data phase; unmapped reads give zero
		nxt_hrdata  = (addr_phase && !hwrite_i) ? rd_word : hrdata_ff;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			hrdata_ff  <= '0;
		end else if (ce_i) begin
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			hrdata_ff  <= nxt_hrdata;
		end
	end

	// zero wait states, always OKAY
	assign hrdata_o    = hrdata_ff;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// -------------------------------------------------------------
	// register writes
	// -------------------------------------------------------------
	always_comb begin
		nxt_period = period_ff;
		nxt_log    = log_ff;
		nxt_scale  = scale_ff;
		nxt_ton1   = ton1_ff;
		nxt_ton2   = ton2_ff;
		nxt_slot   = slot_ff;
		nxt_src    = src_ff;
		nxt_rise   = rise_ff;
		nxt_fall   = fall_ff;
		nxt_cur    = cur_ff;
		restart    = 1'b0;
		if (wr_pend_ff) begin
			case (wr_addr_ff)
				ADDR_PERIOD: begin
					nxt_period = hwdata_i[6:0];
					nxt_log    = hwdata_i[PER_LOG_BIT];
					nxt_scale  = hwdata_i[PER_SCALE_LSB +: 2];
					restart    = 1'b1;
				end
				ADDR_FIRST_BLINK_TIMER: nxt_ton1 = hwdata_i[7:0];
				ADDR_SECOND_BLINK_TIMER: begin
					nxt_ton2 = hwdata_i[7:0];
					nxt_slot = hwdata_i[T2_SLOT_LSB +: 2];
				end
				ADDR_SOURCE: nxt_src = hwdata_i[7:0];
				ADDR_RAMP: begin
					nxt_rise = hwdata_i[3:0];
					nxt_fall = hwdata_i[RAMP_FALL_LSB +: 4];
				end
				default: begin
					for (int n = 0; n < NUM_CH; n++) begin
						if (wr_addr_ff == ADDR_CUR0 + 8'(n) * ADDR_STEP) begin
							nxt_cur[n] = hwdata_i[7:0];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			period_ff <= '0;
			log_ff    <= 1'b0;
			scale_ff  <= '0;
			ton1_ff   <= '0;
			ton2_ff   <= '0;
			slot_ff   <= '0;
			src_ff    <= '0;
			rise_ff   <= '0;
			fall_ff   <= '0;
			cur_ff    <= '0;
		end else if (ce_i) begin
			period_ff <= nxt_period;
			log_ff    <= nxt_log;
			scale_ff  <= nxt_scale;
			ton1_ff   <= nxt_ton1;
			ton2_ff   <= nxt_ton2;
			slot_ff   <= nxt_slot;
			src_ff    <= nxt_src;
			rise_ff   <= nxt_rise;
			fall_ff   <= nxt_fall;
			cur_ff    <= nxt_cur;
		end
	end

	// -------------------------------------------------------------
	// flash period and timers
	// -------------------------------------------------------------
	always_comb begin
		nxt_pstate  = pstate_ff;
		nxt_div     = div_ff;
		nxt_phase   = phase_ff;
		nxt_pwm_cnt = pwm_cnt_ff + 1'b1;
		phase_end   = div_ff >= period_limit(period_ff) - 1'b1;
		t2_start    = SLOT_STEP * {6'h00, slot_ff};
		case (pstate_ff)
			PER_RUN: begin
				if (phase_end) begin
					nxt_div = '0;
					if (phase_ff == PHASE_LAST) begin
						if (period_ff == FP_ONE_SHOT) begin
							nxt_pstate = PER_DONE;
						end
						nxt_phase = '0;
					end else begin
						nxt_phase = phase_ff + 1'b1;
					end
				end else begin
					nxt_div = div_ff + 1'b1;
				end
			end
			PER_DONE: nxt_div = '0;
			default:  nxt_pstate = PER_RUN;
		endcase
		// a period write starts a fresh pattern, also after a one shot
		if (restart) begin
			nxt_pstate = PER_RUN;
			nxt_div    = '0;
			nxt_phase  = '0;
		end
		nxt_t1_on = (nxt_pstate == PER_RUN) && in_window(nxt_phase, 8'h00, ton1_ff);
		nxt_t2_on = (nxt_pstate == PER_RUN) && in_window(nxt_phase, t2_start, ton2_ff);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pstate_ff  <= PER_RUN;
			div_ff     <= '0;
			phase_ff   <= '0;
			t1_on_ff   <= 1'b0;
			t2_on_ff   <= 1'b0;
			pwm_cnt_ff <= '0;
		end else if (ce_i) begin
			pstate_ff  <= nxt_pstate;
			div_ff     <= nxt_div;
			phase_ff   <= nxt_phase;
			t1_on_ff   <= nxt_t1_on;
			t2_on_ff   <= nxt_t2_on;
			pwm_cnt_ff <= nxt_pwm_cnt;
		end
	end

	// -------------------------------------------------------------
	// ramps
	// -------------------------------------------------------------
	brightness_ramp u_ramp1 (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.on_i        (t1_on_ff),
		.rise_code_i (rise_ff),
		.fall_code_i (fall_ff),
		.scale_i     (scale_ff),
		.log_shape_i (log_ff),
		.duty_o      (duty1)
	);

	brightness_ramp u_ramp2 (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.on_i        (t2_on_ff),
		.rise_code_i (rise_ff),
		.fall_code_i (fall_ff),
		.scale_i     (scale_ff),
		.log_shape_i (log_ff),
		.duty_o      (duty2)
	);

	// -------------------------------------------------------------
	// channel outputs
	// -------------------------------------------------------------
	always_comb begin
		for (int n = 0; n < NUM_CH; n++) begin
			case (src_sel_e'(src_ff[2*n +: 2]))
				SRC_OFF:    ch_duty[n] = DUTY_OFF;
				SRC_ON:     ch_duty[n] = DUTY_FULL;
				SRC_FIRST_BLINK_TIMER: ch_duty[n] = duty1;
				SRC_SECOND_BLINK_TIMER: ch_duty[n] = duty2;
				default:    ch_duty[n] = DUTY_OFF;
			endcase
		end
	end

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		pwm_modulator u_pwm (
			.ref_clk_i (ref_clk_i),
			.rst_n_i   (rst_n_i),
			.ce_i      (ce_i),
			.pwm_cnt_i (pwm_cnt_ff),
			.duty_i    (ch_duty[g]),
			.on_o      (ch_on_o[g])
		);
	end

	// current level comes straight from its register
	assign channel_current_level_o = cur_ff;

endmodule // led_pattern_top

// ===== tb/led_pattern_monitor.sv
module led_pattern_monitor
	import led_pattern_pkg::*;
(
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   ce_i,
	input  wire logic                   hsel_i,
	input  wire logic [31:0]            haddr_i,
	input  wire logic [1:0]             htrans_i,
	input  wire logic                   hwrite_i,
	input  wire logic [31:0]            hwdata_i,
	input  wire logic                   hready_i,
	input  wire logic [31:0]            hrdata_o,
	input  wire logic                   hreadyout_o,
	input  wire logic                   hresp_o,
	input  wire logic [NUM_CH-1:0]      ch_on_o,
	input  wire logic [NUM_CH-1:0][7:0] channel_current_level_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// bus tracking
	// ----------------------------------------
	logic       rd_take, cur_hit, rd_cur, wr_ph_ff, nxt_wr_ph;
	logic [7:0] wa_ff, nxt_wa, src_ff, nxt_src;
	logic [3:0] age_ff, nxt_age, on_m, off_m;
	logic [1:0] cidx, ridx;

	assign rd_take = hsel_i & hready_i & htrans_i[1] & ce_i & ~hwrite_i;
	assign cur_hit = wr_ph_ff & ce_i & (wa_ff >= ADDR_CUR0) & (wa_ff <= 8'h20);
	assign rd_cur  = rd_take & (haddr_i[7:0] >= ADDR_CUR0) & (haddr_i[7:0] <= 8'h20);
	assign cidx    = 2'(wa_ff[4:2] - 3'h5);
	assign ridx    = 2'(haddr_i[4:2] - 3'h5);

	// age saturates at 8 so the pwm pipeline has settled
	always_comb begin
		nxt_wr_ph = ce_i ? hsel_i & hready_i & htrans_i[1] & hwrite_i : wr_ph_ff;
		nxt_wa    = ce_i ? haddr_i[7:0] : wa_ff;
		nxt_src   = src_ff;
		nxt_age   = (ce_i && !age_ff[3]) ? age_ff + 4'h1 : age_ff;
		if (wr_ph_ff && ce_i && wa_ff == ADDR_SOURCE) begin
			nxt_src = hwdata_i[7:0];
			nxt_age = 4'h0;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			on_m[i]  = src_ff[2*i +: 2] == SRC_ON;
			off_m[i] = src_ff[2*i +: 2] == SRC_OFF;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wr_ph_ff <= 1'b0;
			wa_ff    <= 8'h00;
			src_ff   <= 8'h00;
			age_ff   <= 4'h0;
		end else begin
			wr_ph_ff <= nxt_wr_ph;
			wa_ff    <= nxt_wa;
			src_ff   <= nxt_src;
			age_ff   <= nxt_age;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rst;
		@(posedge ref_clk_i) !rst_n_i && ce_i |=> ch_on_o == '0
			&& channel_current_level_o == '0 && hrdata_o == '0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not cleared by reset");

	property p_cur_wr;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		cur_hit |=> channel_current_level_o[$past(cidx)] == $past(hwdata_i[7:0]);
	endproperty
	a_cur_wr: assert property (p_cur_wr)
		else $error("current level not taken from write");

	property p_cur_hold;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !cur_hit |=> $stable(channel_current_level_o);
	endproperty
	a_cur_hold: assert property (p_cur_hold)
		else $error("current level moved without write");

	property p_cur_rd;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		rd_cur && !cur_hit |=> hrdata_o == 32'($past(channel_current_level_o[ridx]));
	endproperty
	a_cur_rd: assert property (p_cur_rd)
		else $error("current level read back wrong");

	property p_on;
		@(posedge ref_clk_i) disable iff (!rst_n_i) age_ff[3] |-> (ch_on_o & on_m) == on_m;
	endproperty
	a_on: assert property (p_on)
		else $error("always-on channel not steady on");

	property p_off;
		@(posedge ref_clk_i) disable iff (!rst_n_i) age_ff[3] |-> (ch_on_o & off_m) == '0;
	endproperty
	a_off: assert property (p_off)
		else $error("always-off channel lit");

	property p_hold;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !rd_take |=> $stable(hrdata_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data changed without read");

	property p_unmap;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		rd_take && haddr_i[7:0] > ADDR_STATUS |=> hrdata_o == '0;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");

	property p_okay;
		@(posedge ref_clk_i) disable iff (!rst_n_i) hresp_o == 1'b0 && hreadyout_o == 1'b1;
	endproperty
	a_okay: assert property (p_okay)
		else $error("bus response not ready okay");
endmodule // led_pattern_monitor

bind led_pattern_top led_pattern_monitor led_pattern_monitor_i (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.ch_on_o(ch_on_o), .channel_current_level_o(channel_current_level_o)
);

// ===== tb/ahb_host.sv
module ahb_host
	import led_pattern_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_i,
	output logic             hsel_o,
	output logic      [31:0] haddr_o,
	output logic      [1:0]  htrans_o,
	output logic             hwrite_o,
	output logic      [2:0]  hsize_o,
	output logic      [31:0] hwdata_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		hsel_o   = 1'b0;
		haddr_o  = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o  = 3'h2;
		hwdata_o = 32'h0;
	end

	// released lines show the inverse so stale data cannot pass
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge ref_clk_i);
		hsel_o   <= 1'b1;
		haddr_o  <= {24'h0, a};
		htrans_o <= 2'h2;
		hwrite_o <= wr;
		do @(posedge ref_clk_i); while (hready_i !== 1'b1);
		hsel_o   <= 1'b0;
		htrans_o <= 2'h0;
		haddr_o  <= ~haddr_o;
		hwdata_o <= wr ? d : ~hwdata_o;
		do @(posedge ref_clk_i); while (hready_i !== 1'b1);
		q = hrdata_i;
		hwdata_o <= ~hwdata_o;
	endtask
endmodule // ahb_host

// ===== tb/testbench.sv
`define check_eq(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module testbench
	import led_pattern_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r;} row_s;

	logic                   ref_clk = 1'b0;
	logic                   rst_n   = 1'b0;
	logic                   ce      = 1'b1;
	logic                   hsel, hwrite, hreadyout, hresp;
	logic [31:0]            haddr, hwdata, hrdata, q;
	logic [1:0]             htrans;
	logic [2:0]             hsize;
	logic [NUM_CH-1:0]      ch_on;
	logic [NUM_CH-1:0][7:0] cur_lvl;
	int                     num_errors = 0;
	int                     compares   = 0;
	int                     n_lin, n_log, n_sc;
	row_s                   rows [9] = '{
		'{ADDR_PERIOD, 32'hFFFF_FFFF, 32'h0000_03FF}, '{ADDR_FIRST_BLINK_TIMER, 32'hFFFF_FFFF, 32'h0000_00FF},
		'{ADDR_SECOND_BLINK_TIMER, 32'hFFFF_FFFF, 32'h0000_03FF}, '{ADDR_RAMP, 32'hFFFF_FFFF, 32'h0000_00FF},
		'{ADDR_SOURCE, 32'hFFFF_FFFF, 32'h0000_00FF}, '{8'h28, 32'hFFFF_FFFF, 32'h0000_0000},
		'{ADDR_CUR0, 32'h0000_0011, 32'h0000_0011}, '{8'h18, 32'hFFFF_FF22, 32'h0000_0022},
		'{8'h1C, 32'h0000_0033, 32'h0000_0033}};

	always #2 ref_clk = ~ref_clk;

	ahb_host ahb_host_i (.ref_clk_i(ref_clk), .hready_i(hreadyout), .hrdata_i(hrdata),
		.hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
		.hsize_o(hsize), .hwdata_o(hwdata));

	led_pattern_top led_pattern_top_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .ch_on_o(ch_on),
		.channel_current_level_o(cur_lvl));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		ahb_host_i.xfer(1'b1, a, d, dummy);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		ahb_host_i.xfer(1'b0, a, 32'h0, d);
	endtask

	// polling costs a few cycles of slack per phase
	task automatic wait_phase(input logic [7:0] p);
		logic [31:0] s;
		do rd(ADDR_STATUS, s); while (s[7:0] !== p);
	endtask

	// start the ramp from a dark channel, then count pwm on-cycles
	task automatic ramp_count(input logic [31:0] pv, output int n);
		wr(ADDR_FIRST_BLINK_TIMER, 32'h0);
		wr(ADDR_RAMP, 32'h0);
		wr(ADDR_SOURCE, 32'h02);
		repeat (8) @(posedge ref_clk);
		wr(ADDR_RAMP, 32'h11);
		wr(ADDR_FIRST_BLINK_TIMER, 32'hFF);
		wr(ADDR_PERIOD, pv);
		repeat (2500) @(posedge ref_clk);
		n = 0;
		repeat (256) begin
			@(posedge ref_clk);
			n += int'(ch_on[0]);
		end
	endtask

	task automatic wrap_up;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].w);
			rd(rows[k].a, q);
			`check_eq(q, rows[k].r)
		end
		wr(8'h20, 32'h44);
		@(posedge ref_clk);
		`check_eq(cur_lvl, 32'h4433_2211)
		ce <= 1'b0;
		wr(ADDR_CUR0, 32'h99);
		ce <= 1'b1;
		@(posedge ref_clk);
		`check_eq(cur_lvl[0], 8'h11)
		wr(ADDR_SOURCE, 32'h55);
		repeat (8) @(posedge ref_clk);
		`check_eq(ch_on, 4'hF)
		wr(ADDR_RAMP, 32'h0);
		wr(ADDR_FIRST_BLINK_TIMER, 32'h2);
		wr(ADDR_SOURCE, 32'h08);
		wr(ADDR_PERIOD, 32'h0);
		repeat (100) @(posedge ref_clk);
		`check_eq(ch_on, 4'h2)
		rd(ADDR_STATUS, q);
		`check_eq(q[10:8], 3'b010)
		wait_phase(8'h02);
		repeat (10) @(posedge ref_clk);
		`check_eq(ch_on, 4'h0)
		wr(ADDR_SECOND_BLINK_TIMER, 32'h101);
		wr(ADDR_SOURCE, 32'hC0);
		wait_phase(8'h3F);
		`check_eq(ch_on, 4'h0)
		wait_phase(8'h40);
		repeat (10) @(posedge ref_clk);
		`check_eq(ch_on, 4'h8)
		rd(ADDR_STATUS, q);
		`check_eq(q[10], 1'b1)
		wr(ADDR_PERIOD, 32'h0);
		rd(ADDR_STATUS, q);
		`check_eq(q[7:0], 8'h00)
		ramp_count(32'h000, n_lin);
		`check_eq(n_lin > 0 && n_lin < 256, 1'b1)
		ramp_count(32'h080, n_log);
		`check_eq(n_log < n_lin, 1'b1)
		ramp_count(32'h100, n_sc);
		`check_eq(n_sc > 0 && n_sc < n_lin, 1'b1)
		wr(ADDR_RAMP, 32'h10);
		repeat (8) @(posedge ref_clk);
		`check_eq(ch_on[0], 1'b1)
		wr(ADDR_FIRST_BLINK_TIMER, 32'h0);
		repeat (8) @(posedge ref_clk);
		`check_eq(ch_on[0], 1'b1)
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		`check_eq({ch_on, cur_lvl}, 36'h0)
		wrap_up;
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		num_errors++;
		wrap_up;
	end
endmodule // testbench
